// File: rtl/sub_regs.svh
// register indices, field positions, reset values and frame edge counts
`ifndef SUB_REGS_SVH
`define SUB_REGS_SVH
`define SUB_IDX_DATA     4'h0
`define SUB_IDX_IER      4'h1
`define SUB_IDX_FIFO     4'h2
`define SUB_IDX_LCR      4'h3
`define SUB_IDX_MCR      4'h4
`define SUB_IDX_LSR      4'h5
`define SUB_IDX_MSR      4'h6
`define SUB_IDX_SPR      4'h7
`define SUB_LCR_DIV_BIT  7
`define SUB_LCR_ENH_KEY  8'hBF
`define SUB_LCR_RST      8'h00
`define SUB_IER_RST      8'h01
`define SUB_DIV_RST      16'h0001
`define SUB_EFR_ENH_BIT  4
`define SUB_FCR_EN_BIT   0
`define SUB_FCR_RXR_BIT  1
`define SUB_FCR_TXR_BIT  2
`define SUB_LSR_DR_BIT   0
`define SUB_LSR_THRE_BIT 5
`define SUB_LSR_TEMT_BIT 6
`define SUB_IIR_NONE     4'h1
`define SUB_IIR_THRE     4'h2
`define SUB_IIR_RXD      4'h4
`define SUB_CMD_RD_BIT   7
`define SUB_EDGE_IDX     5'h04
`define SUB_EDGE_LOAD    5'h08
`define SUB_EDGE_DATA    5'h0F
`define SUB_EDGE_LAST    5'h10
`endif

// File: rtl/sub_pkg.sv
// shared types of the bridge host port
package sub_pkg;
    typedef logic [7:0] sub_byte_t;
    typedef enum logic [1:0] {BANK_NORMAL, BANK_DIVISOR, BANK_ENHANCED} sub_bank_t;
endpackage

// File: rtl/sub_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sub_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
    logic         head_v_r, head_v_nxt, tail_v_r, tail_v_nxt, rdy_r, rdy_nxt;

    always_comb begin
        head_nxt   = head_r;
        tail_nxt   = tail_r;
        head_v_nxt = head_v_r;
        tail_v_nxt = tail_v_r;
        if (out_valid && out_ready) begin
            head_nxt   = tail_r;
            head_v_nxt = tail_v_r;
            tail_v_nxt = 1'b0;
        end
        if (in_valid && rdy_r) begin
            if (!head_v_nxt) begin
                head_nxt   = in_data;
                head_v_nxt = 1'b1;
            end else begin
                tail_nxt   = in_data;
                tail_v_nxt = 1'b1;
            end
        end
        if (flush) begin
            head_v_nxt = 1'b0;
            tail_v_nxt = 1'b0;
        end
        rdy_nxt = !tail_v_nxt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_r   <= '0;
            tail_r   <= '0;
            head_v_r <= 1'b0;
            tail_v_r <= 1'b0;
            rdy_r    <= 1'b0;
        end else begin
            head_r   <= head_nxt;
            tail_r   <= tail_nxt;
            head_v_r <= head_v_nxt;
            tail_v_r <= tail_v_nxt;
            rdy_r    <= rdy_nxt;
        end
    end

    assign in_ready  = rdy_r;
    assign out_data  = head_r;
    assign out_valid = head_v_r;
endmodule

// File: rtl/sub_spi_link.sv
// serial link end of the host port, clocked by the host's serial clock
`timescale 1ns/1ps
`include "sub_regs.svh"
module sub_spi_link (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    input  wire logic       rst_n,
    input  wire logic       link_en,
    input  wire logic [7:0] rd_data,
    output logic            miso,
    output logic            miso_oe,
    output logic            rd_tgl,
    output logic [3:0]      rd_idx,
    output logic            wr_tgl,
    output logic [3:0]      wr_idx,
    output logic [7:0]      wr_data
);
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, out_r, out_nxt;
    logic [3:0] cidx_r, cidx_nxt, rdi_r, rdi_nxt, wri_r, wri_nxt;
    logic [7:0] wrd_r, wrd_nxt;
    logic       crd_r, crd_nxt, rdt_r, rdt_nxt, wrt_r, wrt_nxt, so_r, so_nxt, oe_r, oe_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // sample on rising
    always_comb begin
        cnt_nxt  = (cnt_r == `SUB_EDGE_LAST) ? cnt_r : cnt_r + 5'h01;
        sh_nxt   = {sh_r[6:0], mosi};
        cidx_nxt = cidx_r;
        crd_nxt  = crd_r;
        rdi_nxt  = rdi_r;
        rdt_nxt  = rdt_r;
        wri_nxt  = wri_r;
        wrd_nxt  = wrd_r;
        wrt_nxt  = wrt_r;
        if (cnt_r == `SUB_EDGE_IDX) begin
            cidx_nxt = {sh_r[2:0], mosi};
            crd_nxt  = sh_r[3];
            if (sh_r[3] && link_en) begin
                rdi_nxt = {sh_r[2:0], mosi};
                rdt_nxt = !rdt_r;
            end
        end
        if (cnt_r == `SUB_EDGE_DATA && !crd_r && link_en) begin
            wri_nxt = cidx_r;
            wrd_nxt = {sh_r[6:0], mosi};
            wrt_nxt = !wrt_r;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_r  <= 5'h00;
            sh_r   <= 8'h00;
            cidx_r <= 4'h0;
            crd_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            cidx_r <= cidx_nxt;
            crd_r  <= crd_nxt;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rdi_r <= 4'h0;
            rdt_r <= 1'b0;
            wri_r <= 4'h0;
            wrd_r <= 8'h00;
            wrt_r <= 1'b0;
        end else begin
            rdi_r <= rdi_nxt;
            rdt_r <= rdt_nxt;
            wri_r <= wri_nxt;
            wrd_r <= wrd_nxt;
            wrt_r <= wrt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // msb first on falling
    always_comb begin
        out_nxt = {out_r[6:0], 1'b0};
        so_nxt  = out_r[6];
        oe_nxt  = link_en;
        if (cnt_r == `SUB_EDGE_LOAD) begin
            out_nxt = crd_r ? rd_data : 8'h00;
            so_nxt  = crd_r & rd_data[7];
        end else if (cnt_r < `SUB_EDGE_LOAD) begin
            so_nxt = 1'b0;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_r <= 8'h00;
            so_r  <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            out_r <= out_nxt;
            so_r  <= so_nxt;
            oe_r  <= oe_nxt;
        end
    end

    a_rd_request: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
        (cnt_r == `SUB_EDGE_IDX && sh_r[3] && link_en) |=> (rdt_r != $past(rdt_r)))
        else $error("read request not raised after index bits");
    a_wr_capture: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
        (cnt_r == `SUB_EDGE_DATA && !crd_r && link_en) |=> (wrd_r == $past(sh_nxt)))
        else $error("write byte not captured at frame end");

    assign miso    = so_r;
    assign miso_oe = oe_r;
    assign rd_tgl  = rdt_r;
    assign rd_idx  = rdi_r;
    assign wr_tgl  = wrt_r;
    assign wr_idx  = wri_r;
    assign wr_data = wrd_r;
endmodule

// File: rtl/sub_bridge_port.sv
// serial host port of the bridge: link, register bank, buffers, interrupt
`timescale 1ns/1ps
`include "sub_regs.svh"
// Behaviour
// - interface pin low selects serial link
// - four wires: miso, mosi, select, clock
// - deselected device ignores link, output off
// - arriving data pulls interrupt output low
// - line control 0x80 opens divisor latches
// - divisor sets bit rate from crystal
// - 0xBF exposes enhanced register, 0x10 enables
// - 0x03 gives 8N1, closes divisor
// - fifo 0x06 clears both, 0x01 enables
// - status bit 0 flags waiting data
// - identification 0x02 means transmit room
// - read frame: index byte, dummy byte
// - write frame: index byte, data byte
module sub_bridge_port (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        if_select_in,
    input  wire logic        serial_clock_in,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             irq_n,
    output logic             spi_selected,
    output logic [15:0]      baud_divisor,
    output logic             baud_tick_16x,
    output logic [7:0]       line_control,
    output logic [7:0]       modem_control,
    output logic             fifo_enable,
    output logic             enhanced_enable
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    // strap synchroniser runs on the raw reset so it is full when logic leaves reset
    logic rst_s1_r, rst_n_r, if_s1_r, if_s2_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
            if_s1_r  <= 1'b1;
            if_s2_r  <= 1'b1;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
            if_s1_r  <= if_select_in;
            if_s2_r  <= if_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interface strap, caught once after release
    logic strap_done_r, strap_done_nxt, spi_sel_r, spi_sel_nxt;

    always_comb begin
        strap_done_nxt = 1'b1;
        spi_sel_nxt    = spi_sel_r;
        if (!strap_done_r) begin
            spi_sel_nxt = !if_s2_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            strap_done_r <= 1'b0;
            spi_sel_r    <= 1'b0;
        end else begin
            strap_done_r <= strap_done_nxt;
            spi_sel_r    <= spi_sel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link end on the serial clock
    logic       l_rd_tgl, l_wr_tgl;
    logic [3:0] l_rd_idx, l_wr_idx;
    logic [7:0] l_wr_data;
    sub_pkg::sub_byte_t rd_data_r, rd_data_nxt;

    sub_spi_link u_link (
        .sclk    (serial_clock_in),
        .cs_n    (spi_cs_n),
        .mosi    (spi_mosi),
        .rst_n   (rst_n_r),
        .link_en (spi_sel_r),
        .rd_data (rd_data_r),
        .miso    (spi_miso),
        .miso_oe (spi_miso_oe),
        .rd_tgl  (l_rd_tgl),
        .rd_idx  (l_rd_idx),
        .wr_tgl  (l_wr_tgl),
        .wr_idx  (l_wr_idx),
        .wr_data (l_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // toggle crossing; index and data words are held still by the link meanwhile
    logic rd_s1_r, rd_s2_r, rd_s3_r, wr_s1_r, wr_s2_r, wr_s3_r;
    logic rd_evt, wr_evt;

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_s3_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
        end else begin
            rd_s1_r <= l_rd_tgl;
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
            wr_s1_r <= l_wr_tgl;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
        end
    end

    assign rd_evt = (rd_s2_r ^ rd_s3_r) & spi_sel_r;
    assign wr_evt = (wr_s2_r ^ wr_s3_r) & spi_sel_r;

    ////////////////////////////////////////////////////////////////////////////////
    // receive and transmit buffers
    logic [7:0] rhr_data;
    logic       rhr_valid, rhr_pop, thr_room, thr_push;
    logic       rx_flush, tx_flush;

    sub_buf2 #(.W(8)) u_rx_buf (
        .clk       (sys_clk),
        .rst_n     (rst_n_r),
        .flush     (rx_flush),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (rhr_data),
        .out_valid (rhr_valid),
        .out_ready (rhr_pop)
    );

    sub_buf2 #(.W(8)) u_tx_buf (
        .clk       (sys_clk),
        .rst_n     (rst_n_r),
        .flush     (tx_flush),
        .in_data   (l_wr_data),
        .in_valid  (thr_push),
        .in_ready  (thr_room),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register bank
    logic [7:0] lcr_r, lcr_nxt, dll_r, dll_nxt, dlm_r, dlm_nxt, ier_r, ier_nxt;
    logic [7:0] efr_r, efr_nxt, mcr_r, mcr_nxt, spr_r, spr_nxt;
    logic       fen_r, fen_nxt;
    logic [3:0] iir_code;
    logic [7:0] lsr_val;
    sub_pkg::sub_bank_t bank;

    always_comb begin
        if (lcr_r == `SUB_LCR_ENH_KEY) begin
            bank = sub_pkg::BANK_ENHANCED;
        end else if (lcr_r[`SUB_LCR_DIV_BIT]) begin
            bank = sub_pkg::BANK_DIVISOR;
        end else begin
            bank = sub_pkg::BANK_NORMAL;
        end
        if (ier_r[0] && rhr_valid) begin
            iir_code = `SUB_IIR_RXD;
        end else if (ier_r[1] && thr_room) begin
            iir_code = `SUB_IIR_THRE;
        end else begin
            iir_code = `SUB_IIR_NONE;
        end
        lsr_val = 8'h00;
        lsr_val[`SUB_LSR_DR_BIT]   = rhr_valid;
        lsr_val[`SUB_LSR_THRE_BIT] = thr_room;
        lsr_val[`SUB_LSR_TEMT_BIT] = thr_room & !tx_valid;
    end

    always_comb begin
        lcr_nxt  = lcr_r;
        dll_nxt  = dll_r;
        dlm_nxt  = dlm_r;
        ier_nxt  = ier_r;
        efr_nxt  = efr_r;
        mcr_nxt  = mcr_r;
        spr_nxt  = spr_r;
        fen_nxt  = fen_r;
        rx_flush = 1'b0;
        tx_flush = 1'b0;
        thr_push = 1'b0;
        if (wr_evt) begin
            if (l_wr_idx == `SUB_IDX_DATA) begin
                if (bank != sub_pkg::BANK_NORMAL) begin
                    dll_nxt = l_wr_data;
                end else begin
                    // full buffer drops the byte; host watches the room flag
                    thr_push = 1'b1;
                end
            end else if (l_wr_idx == `SUB_IDX_IER) begin
                if (bank != sub_pkg::BANK_NORMAL) begin
                    dlm_nxt = l_wr_data;
                end else begin
                    ier_nxt = l_wr_data;
                end
            end else if (l_wr_idx == `SUB_IDX_FIFO) begin
                if (bank == sub_pkg::BANK_ENHANCED) begin
                    efr_nxt = l_wr_data;
                end else begin
                    fen_nxt  = l_wr_data[`SUB_FCR_EN_BIT];
                    rx_flush = l_wr_data[`SUB_FCR_RXR_BIT];
                    tx_flush = l_wr_data[`SUB_FCR_TXR_BIT];
                end
            end else if (l_wr_idx == `SUB_IDX_LCR) begin
                lcr_nxt = l_wr_data;
            end else if (l_wr_idx == `SUB_IDX_MCR) begin
                mcr_nxt = l_wr_data;
            end else if (l_wr_idx == `SUB_IDX_SPR) begin
                spr_nxt = l_wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lcr_r <= `SUB_LCR_RST;
            dll_r <= 8'(`SUB_DIV_RST & 16'h00FF);
            dlm_r <= 8'h00;
            ier_r <= `SUB_IER_RST;
            efr_r <= 8'h00;
            mcr_r <= 8'h00;
            spr_r <= 8'h00;
            fen_r <= 1'b0;
        end else begin
            lcr_r <= lcr_nxt;
            dll_r <= dll_nxt;
            dlm_r <= dlm_nxt;
            ier_r <= ier_nxt;
            efr_r <= efr_nxt;
            mcr_r <= mcr_nxt;
            spr_r <= spr_nxt;
            fen_r <= fen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read answer, held for the link to shift out
    always_comb begin
        rd_data_nxt = rd_data_r;
        rhr_pop     = 1'b0;
        if (rd_evt) begin
            if (l_rd_idx == `SUB_IDX_DATA) begin
                if (bank != sub_pkg::BANK_NORMAL) begin
                    rd_data_nxt = dll_r;
                end else begin
                    rd_data_nxt = rhr_valid ? rhr_data : 8'h00;
                    rhr_pop     = rhr_valid;
                end
            end else if (l_rd_idx == `SUB_IDX_IER) begin
                rd_data_nxt = (bank != sub_pkg::BANK_NORMAL) ? dlm_r : ier_r;
            end else if (l_rd_idx == `SUB_IDX_FIFO) begin
                rd_data_nxt = (bank == sub_pkg::BANK_ENHANCED) ? efr_r :
                              {{2{fen_r}}, 2'b00, iir_code};
            end else if (l_rd_idx == `SUB_IDX_LCR) begin
                rd_data_nxt = lcr_r;
            end else if (l_rd_idx == `SUB_IDX_MCR) begin
                rd_data_nxt = mcr_r;
            end else if (l_rd_idx == `SUB_IDX_LSR) begin
                rd_data_nxt = lsr_val;
            end else if (l_rd_idx == `SUB_IDX_SPR) begin
                rd_data_nxt = spr_r;
            end else begin
                rd_data_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt output and baud tick
    logic        irq_n_r, irq_n_nxt, tick_r, tick_nxt;
    logic [15:0] bcnt_r, bcnt_nxt;

    always_comb begin
        irq_n_nxt = (iir_code == `SUB_IIR_NONE);
        tick_nxt  = 1'b0;
        bcnt_nxt  = bcnt_r + 16'h0001;
        if ({dlm_r, dll_r} == 16'h0000) begin
            bcnt_nxt = 16'h0000;
        end else if (bcnt_r >= {dlm_r, dll_r} - 16'h0001) begin
            bcnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_n_r <= 1'b1;
            tick_r  <= 1'b0;
            bcnt_r  <= 16'h0000;
        end else begin
            irq_n_r <= irq_n_nxt;
            tick_r  <= tick_nxt;
            bcnt_r  <= bcnt_nxt;
        end
    end

    assign irq_n           = irq_n_r;
    assign baud_tick_16x   = tick_r;
    assign spi_selected    = spi_sel_r;
    assign baud_divisor    = {dlm_r, dll_r};
    assign line_control    = lcr_r;
    assign modem_control   = mcr_r;
    assign fifo_enable     = fen_r;
    assign enhanced_enable = efr_r[`SUB_EFR_ENH_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_strap_select: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (!strap_done_r && !if_s2_r) |=> spi_selected)
        else $error("low strap did not select serial link");
    a_miso_idle: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        spi_cs_n |-> !spi_miso_oe)
        else $error("output driven while deselected");
    a_irq_rx_data: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (rhr_valid && ier_r[0]) |=> !irq_n)
        else $error("interrupt not asserted for waiting data");
    a_div_open: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (wr_evt && l_wr_idx == `SUB_IDX_LCR && l_wr_data == 8'h80)
        |=> (bank == sub_pkg::BANK_DIVISOR))
        else $error("divisor latches not opened");
    a_efr_enable: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (wr_evt && bank == sub_pkg::BANK_ENHANCED && l_wr_idx == `SUB_IDX_FIFO
         && l_wr_data == 8'h10) |=> enhanced_enable)
        else $error("enhanced set not enabled");
    a_lcr_format: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (wr_evt && l_wr_idx == `SUB_IDX_LCR && l_wr_data == 8'h03)
        |=> (line_control == 8'h03 && bank == sub_pkg::BANK_NORMAL))
        else $error("line format not set or divisor left open");
    a_fifo_clear: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (wr_evt && bank != sub_pkg::BANK_ENHANCED && l_wr_idx == `SUB_IDX_FIFO
         && l_wr_data == 8'h06) |=> (!rhr_valid && !tx_valid && !fifo_enable))
        else $error("fifo clear did not empty buffers");
    a_lsr_ready: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (rd_evt && l_rd_idx == `SUB_IDX_LSR) |=> (rd_data_r[0] == $past(rhr_valid)))
        else $error("status data-ready bit wrong");
    a_iir_thre: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (rd_evt && l_rd_idx == `SUB_IDX_FIFO && bank != sub_pkg::BANK_ENHANCED
         && ier_r[1] && thr_room && !(ier_r[0] && rhr_valid))
        |=> (rd_data_r[3:0] == 4'h2))
        else $error("transmit room code not reported");
    a_baud_period: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (tick_r && baud_divisor == 16'h0008 && !wr_evt)
        |=> (!tick_r)[*7] ##1 tick_r)
        else $error("baud tick period not equal to divisor");
endmodule

// File: testbench/sub_host_model.sv
// host serial master model, mode 0, msb first
`timescale 1ns/1ps
module sub_host_model (
    output logic     sclk,
    output logic     cs_n,
    output logic     mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one two-byte frame
    task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = tx[i];
            #24 sclk = 1'b1;
            if (i < 8) rx[i] = miso;
            #24 sclk = 1'b0;
        end
        #10 cs_n = 1'b1;
        // released line shows no stale bit
        mosi = ~mosi;
        #100;
    endtask
endmodule

// File: testbench/sub_bridge_port_tb.sv
// self-checking bench of the bridge host port
`timescale 1ns/1ps
module sub_bridge_port_tb;
    logic        sys_clk = 1'b0;
    logic        arst_n, if_select_in, rx_valid, tx_ready;
    logic        serial_clock_in, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic        rx_ready, tx_valid, irq_n, spi_selected, baud_tick_16x;
    logic        fifo_enable, enhanced_enable;
    logic [7:0]  rx_data, tx_data, line_control, modem_control, rd;
    logic [15:0] baud_divisor;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          ticks = 0;
    sub_bridge_port dut_u (.sys_clk, .arst_n, .if_select_in, .serial_clock_in,
        .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .rx_data, .rx_valid,
        .rx_ready, .tx_data, .tx_valid, .tx_ready, .irq_n, .spi_selected,
        .baud_divisor, .baud_tick_16x, .line_control, .modem_control,
        .fifo_enable, .enhanced_enable);
    sub_host_model host_u (.sclk(serial_clock_in), .cs_n(spi_cs_n),
        .mosi(spi_mosi), .miso(spi_miso));
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        host_u.frame({1'b0, idx, 3'b000, d}, rd);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic rdr(input logic [3:0] idx);
        host_u.frame({1'b1, idx, 3'b000, 8'h00}, rd);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, if_select_in, rx_valid, tx_ready, rx_data} = '0;
        repeat (10) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("selected", 16'h0001, {15'h0, spi_selected});
        wr(4'h3, 8'h80);
        chk("lcr", 16'h0080, {8'h0, line_control});
        wr(4'h0, 8'h30);
        wr(4'h1, 8'h00);
        chk("divisor", 16'h0030, baud_divisor);
        wr(4'h3, 8'hBF);
        wr(4'h2, 8'h10);
        chk("enh", 16'h0001, {15'h0, enhanced_enable});
        wr(4'h3, 8'h03);
        chk("lcr", 16'h0003, {8'h0, line_control});
        wr(4'h2, 8'h06);
        chk("fifo", 16'h0000, {15'h0, fifo_enable});
        wr(4'h2, 8'h01);
        chk("fifo", 16'h0001, {15'h0, fifo_enable});
        wr(4'h3, 8'h80);
        wr(4'h0, 8'h08);
        chk("divisor", 16'h0008, baud_divisor);
        repeat (80) begin
            @(negedge sys_clk);
            ticks += baud_tick_16x;
        end
        chk("ticks", 16'h000A, ticks[15:0]);
        wr(4'h3, 8'h03);
        wr(4'h4, 8'hA5);
        chk("mcr", 16'h00A5, {8'h0, modem_control});
        chk("rxrdy", 16'h0001, {15'h0, rx_ready});
        $display("config test done");
        rx_data = 8'h5A;
        rx_valid = 1'b1;
        @(negedge sys_clk);
        rx_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("irq", 16'h0000, {15'h0, irq_n});
        rdr(4'h5);
        chk("lsr0", 16'h0001, {15'h0, rd[0]});
        rdr(4'h0);
        chk("rhr", 16'h005A, {8'h0, rd});
        chk("oe", 16'h0000, {15'h0, spi_miso_oe});
        $display("receive test done");
        wr(4'h1, 8'h02);
        rdr(4'h2);
        chk("iir", 16'h00C2, {8'h0, rd});
        wr(4'h0, 8'hC3);
        chk("txd", 16'h01C3, {7'h0, tx_valid, tx_data});
        tx_ready = 1'b1;
        @(negedge sys_clk);
        tx_ready = 1'b0;
        @(negedge sys_clk);
        chk("txv", 16'h0000, {15'h0, tx_valid});
        $display("transmit test done");
        close_out();
    end
endmodule
